//--- hdl/fsp_pkg.sv
package fsp_pkg;

  localparam int          FSP_ROW_WORDS  = 32;
  localparam int          FSP_ROW_BYTES  = 96;
  localparam int          FSP_IDX_W      = 5;
  localparam int          FSP_WORD_W     = 24;
  localparam int          FSP_AXI_AW     = 16;

  // Register indices; byte address is four times the index
  localparam logic [11:0] FSP_CTRL_IDX   = 12'h760;
  localparam logic [11:0] FSP_KEY_IDX    = 12'h766;
  localparam logic [15:0] FSP_CTRL_ADDR  = {2'h0, FSP_CTRL_IDX, 2'h0};
  localparam logic [15:0] FSP_KEY_ADDR   = {2'h0, FSP_KEY_IDX, 2'h0};
  localparam logic [15:0] FSP_PTR_ADDR   = 16'h1e00;
  localparam logic [15:0] FSP_STAT_ADDR  = 16'h1e04;
  localparam logic [15:0] FSP_MASK_ADDR  = 16'h1e08;

  localparam int          FSP_GO_BIT     = 15;
  localparam int          FSP_PROGRAM_WRITE_ENABLE_BIT   = 14;
  localparam int          FSP_ERR_BIT    = 13;
  localparam int          FSP_PONLY_BIT  = 12;
  localparam int          FSP_ERASE_BIT  = 6;
  localparam logic [15:0] FSP_CTRL_WMASK = 16'h507f;
  localparam logic [15:0] FSP_CTRL_RST   = 16'h0000;

  localparam logic [7:0]  FSP_KEY1       = 8'h55;
  localparam logic [7:0]  FSP_KEY2       = 8'haa;

  localparam logic [5:0]  FSP_OP_ERASE1  = 6'h18;
  localparam logic [5:0]  FSP_OP_ERASE2  = 6'h19;
  localparam logic [5:0]  FSP_OP_ERASE4  = 6'h1a;
  localparam logic [5:0]  FSP_OP_PROG    = 6'h04;
  localparam logic [2:0]  FSP_ROWS_1     = 3'h1;
  localparam logic [2:0]  FSP_ROWS_2     = 3'h2;
  localparam logic [2:0]  FSP_ROWS_4     = 3'h4;

  localparam int          FSP_ST_DONE    = 0;
  localparam int          FSP_ST_ERR     = 1;

  localparam logic [1:0]  FSP_OKAY       = 2'h0;
  localparam logic [1:0]  FSP_SLVERR     = 2'h2;

  typedef enum logic [2:0] {
    FSP_IDLE,
    FSP_ERASE,
    FSP_FETCH,
    FSP_ISSUE,
    FSP_WAIT
  } fsp_state_type;

endpackage : fsp_pkg

//--- hdl/fsp_latch_if.sv
`timescale 1ns/1ps
`default_nettype none
interface fsp_latch_if;
  logic                          wr_en;
  logic [fsp_pkg::FSP_IDX_W-1:0]  wr_idx;
  logic [fsp_pkg::FSP_WORD_W-1:0] wr_data;
  logic [fsp_pkg::FSP_IDX_W-1:0]  rd_idx;
  logic [fsp_pkg::FSP_WORD_W-1:0] rd_data;
  logic                          rd_loaded;
  logic                          clear;
  modport seq (output wr_en, wr_idx, wr_data, rd_idx, clear, input rd_data, rd_loaded);
  modport mem (input wr_en, wr_idx, wr_data, rd_idx, clear, output rd_data, rd_loaded);
endinterface : fsp_latch_if
`default_nettype wire

//--- hdl/fsp_latch_mem.sv
`timescale 1ns/1ps
`default_nettype none
module fsp_latch_mem (
  input wire logic clock,
  input wire logic rst,
  fsp_latch_if.mem m
);

  typedef struct packed {
    logic [fsp_pkg::FSP_ROW_WORDS-1:0][fsp_pkg::FSP_WORD_W-1:0] data;
    logic [fsp_pkg::FSP_ROW_WORDS-1:0]                          loaded;
    logic [fsp_pkg::FSP_WORD_W-1:0]                             rd;
    logic                                                       rd_ld;
  } fsp_mem_type;

  fsp_mem_type s;
  fsp_mem_type n;

  always_comb begin
    n = s;
    if (m.clear) begin
      n.loaded = '0;
    end
    // A reload simply overwrites; load order is free
    if (m.wr_en) begin
      n.data[m.wr_idx]   = m.wr_data; // RQ5 RQ7 RQ8
      n.loaded[m.wr_idx] = 1'b1;
    end
    n.rd    = s.data[m.rd_idx];
    n.rd_ld = s.loaded[m.rd_idx];
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      s <= '0;
    end else begin
      s <= n;
    end
  end

  assign m.rd_data   = s.rd;
  assign m.rd_loaded = s.rd_ld;

  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);

  chk_latch_replace: assert property ( // RQ8
    m.wr_en |=> (s.data[$past(m.wr_idx)] == $past(m.wr_data)) && s.loaded[$past(m.wr_idx)])
    else $error("latch did not take the newest value");

  chk_latch_hold: assert property ( // RQ5
    !m.wr_en |=> s.data == $past(s.data))
    else $error("latch contents changed without a load");

endmodule : fsp_latch_mem
`default_nettype wire

//--- hdl/fsp_sequencer.sv
`timescale 1ns/1ps
`default_nettype none
// Overview of operation
// RQ1: A row holds 32 instruction words, 96 bytes of storage.
// RQ2: Erase clears one, two or four rows as the operation code selects.
// RQ3: A program operation writes exactly one row, never more.
// RQ4: Erase and write blocks align to their own size; low address bits ignored.
// RQ5: Table writes land in holding latches, kept until a program transfers them.
// RQ6: Any number of latch loads programs fine; unloaded positions add no data.
// RQ7: Latches load in any order and may be rewritten before programming.
// RQ8: Reloading a latch fully replaces its older value.
// RQ9: Software should not reprogram a location without erasing its row first.
// RQ10: Each table write is a two-cycle single-word transfer, no array access.
// RQ11: Each row needs its own program operation.
// RQ12: Software sets the pointer, loads latches, then sets the launch bits.
// RQ13: Operations need key bytes 55h then AAh written consecutively.
// RQ14: Go bit 15 starts the operation; hardware clears it when finished.
// RQ15: The processor is stalled while an operation runs.
// RQ16: Go works only with write enable set right after the unlock sequence.
// RQ17: An aborted or failed operation sets a sticky error flag.
module fsp_sequencer #(
  parameter int ROW_W = 8
) (
  input  wire logic                               clock,
  input  wire logic                               rst,
  input  wire logic [fsp_pkg::FSP_AXI_AW-1:0]     s_axi_awaddr,
  input  wire logic                               s_axi_awvalid,
  output logic                                    s_axi_awready,
  input  wire logic [31:0]                        s_axi_wdata,
  input  wire logic [3:0]                         s_axi_wstrb,
  input  wire logic                               s_axi_wvalid,
  output logic                                    s_axi_wready,
  output logic [1:0]                              s_axi_bresp,
  output logic                                    s_axi_bvalid,
  input  wire logic                               s_axi_bready,
  input  wire logic [fsp_pkg::FSP_AXI_AW-1:0]     s_axi_araddr,
  input  wire logic                               s_axi_arvalid,
  output logic                                    s_axi_arready,
  output logic [31:0]                             s_axi_rdata,
  output logic [1:0]                              s_axi_rresp,
  output logic                                    s_axi_rvalid,
  input  wire logic                               s_axi_rready,
  input  wire logic                               tw_valid,
  input  wire logic [fsp_pkg::FSP_IDX_W-1:0]      tw_index,
  input  wire logic [fsp_pkg::FSP_WORD_W-1:0]     tw_data,
  output logic                                    tw_ready,
  output logic                                    flash_req,
  output logic                                    flash_erase,
  output logic [ROW_W+fsp_pkg::FSP_IDX_W-1:0]     flash_addr,
  output logic [2:0]                              flash_rows,
  output logic [fsp_pkg::FSP_WORD_W-1:0]          flash_wdata,
  input  wire logic                               flash_ack,
  input  wire logic                               flash_fail,
  output logic                                    cpu_stall,
  output logic                                    irq
);

  typedef struct packed {
    fsp_pkg::fsp_state_type                 st;
    logic                                   aw_ok;
    logic [fsp_pkg::FSP_AXI_AW-1:0]         aw_a;
    logic                                   w_ok;
    logic [31:0]                            w_d;
    logic [3:0]                             w_s;
    logic                                   bvalid;
    logic [1:0]                             bresp;
    logic                                   rvalid;
    logic [31:0]                            rdata;
    logic [1:0]                             rresp;
    logic [15:0]                            ctrl;
    logic                                   key1;
    logic                                   armed;
    logic [ROW_W-1:0]                       ptr;
    logic [1:0]                             stat;
    logic [1:0]                             mask;
    logic                                   tw_busy;
    logic [fsp_pkg::FSP_IDX_W-1:0]          idx;
    logic                                   req;
    logic                                   ers;
    logic [ROW_W+fsp_pkg::FSP_IDX_W-1:0]    faddr;
    logic [2:0]                             rows;
    logic [fsp_pkg::FSP_WORD_W-1:0]         wd;
    logic                                   clr;
  } fsp_regs_type;

  fsp_regs_type s;
  fsp_regs_type n;
  fsp_latch_if  lat ();

  logic [15:0]      bmask;
  logic [15:0]      wd16;
  logic             done_ev;
  logic             fail_ev;
  logic             adv;
  logic [2:0]       rsel;
  logic [ROW_W-1:0] blk_mask;

  fsp_latch_mem u_mem (
    .clock (clock),
    .rst   (rst),
    .m     (lat.mem)
  );

  assign lat.wr_en   = tw_valid && tw_ready;
  assign lat.wr_idx  = tw_index;
  assign lat.wr_data = tw_data;
  assign lat.rd_idx  = s.idx;
  assign lat.clear   = s.clr;

  always_comb begin
    n        = s;
    bmask    = {{8{s.w_s[1]}}, {8{s.w_s[0]}}};
    wd16     = s.w_d[15:0];
    done_ev  = 1'b0;
    fail_ev  = 1'b0;
    adv      = 1'b0;
    rsel     = fsp_pkg::FSP_ROWS_1;
    blk_mask = '1;
    n.clr    = 1'b0;

    if (s.bvalid && s_axi_bready) begin
      n.bvalid = 1'b0;
    end
    if (s.rvalid && s_axi_rready) begin
      n.rvalid = 1'b0;
    end
    if (s_axi_awvalid && s_axi_awready) begin
      n.aw_ok = 1'b1;
      n.aw_a  = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      n.w_ok = 1'b1;
      n.w_d  = s_axi_wdata;
      n.w_s  = s_axi_wstrb;
    end
    if (s_axi_arvalid && s_axi_arready) begin
      n.rvalid = 1'b1;
      n.rresp  = fsp_pkg::FSP_OKAY;
      case (s_axi_araddr)
        fsp_pkg::FSP_CTRL_ADDR: n.rdata = {16'h0000, s.ctrl};
        fsp_pkg::FSP_KEY_ADDR:  n.rdata = 32'h0000_0000;
        fsp_pkg::FSP_PTR_ADDR:  n.rdata = 32'(s.ptr);
        fsp_pkg::FSP_STAT_ADDR: n.rdata = {30'h0, s.stat};
        fsp_pkg::FSP_MASK_ADDR: n.rdata = {30'h0, s.mask};
        default: begin
          n.rdata = 32'h0000_0000;
          n.rresp = fsp_pkg::FSP_SLVERR;
        end
      endcase
    end

    // Second cycle of a latch load: no new load, no array traffic
    n.tw_busy = tw_valid && tw_ready; // RQ10

    case (s.st)
      fsp_pkg::FSP_IDLE: begin
      end
      fsp_pkg::FSP_ERASE: begin
        if (flash_ack) begin
          n.req   = 1'b0;
          fail_ev = flash_fail; // RQ17
          done_ev = !flash_fail;
        end
      end
      fsp_pkg::FSP_FETCH: begin
        n.st = fsp_pkg::FSP_ISSUE;
      end
      fsp_pkg::FSP_ISSUE: begin
        // Positions never loaded are skipped, leaving the array word as it is
        if (lat.rd_loaded) begin // RQ6
          n.req   = 1'b1;
          n.faddr = {s.ptr, s.idx}; // RQ3
          n.wd    = lat.rd_data;
          n.st    = fsp_pkg::FSP_WAIT;
        end else begin
          adv = 1'b1;
        end
      end
      fsp_pkg::FSP_WAIT: begin
        if (flash_ack) begin
          n.req = 1'b0;
          if (flash_fail) begin
            fail_ev = 1'b1; // RQ17
          end else begin
            adv = 1'b1;
          end
        end
      end
      default: begin
        n.st = fsp_pkg::FSP_IDLE;
      end
    endcase

    if (adv) begin
      if (s.idx == fsp_pkg::FSP_IDX_W'(fsp_pkg::FSP_ROW_WORDS - 1)) begin // RQ1 RQ3
        done_ev = 1'b1;
        n.clr   = 1'b1;
      end else begin
        n.idx = s.idx + 1'b1;
        n.st  = fsp_pkg::FSP_FETCH;
      end
    end
    if (done_ev || fail_ev) begin
      n.st                     = fsp_pkg::FSP_IDLE;
      n.ctrl[fsp_pkg::FSP_GO_BIT] = 1'b0; // RQ14
    end

    if (s.aw_ok && s.w_ok && !s.bvalid) begin
      n.aw_ok  = 1'b0;
      n.w_ok   = 1'b0;
      n.bvalid = 1'b1;
      n.bresp  = fsp_pkg::FSP_OKAY;
      // Any write other than the key pair breaks the unlock
      n.key1   = 1'b0; // RQ13
      n.armed  = 1'b0; // RQ16
      case (s.aw_a)
        fsp_pkg::FSP_KEY_ADDR: begin
          if (s.w_s[0] && wd16[7:0] == fsp_pkg::FSP_KEY1) begin // RQ13
            n.key1 = 1'b1;
          end else if (s.w_s[0] && s.key1 && wd16[7:0] == fsp_pkg::FSP_KEY2) begin
            n.armed = 1'b1;
          end
        end
        fsp_pkg::FSP_CTRL_ADDR: begin
          if (s.st == fsp_pkg::FSP_IDLE) begin
            n.ctrl = (s.ctrl & ~(bmask & fsp_pkg::FSP_CTRL_WMASK)) | (wd16 & bmask & fsp_pkg::FSP_CTRL_WMASK);
          end
          if (s.w_s[1] && !wd16[fsp_pkg::FSP_ERR_BIT]) begin
            n.ctrl[fsp_pkg::FSP_ERR_BIT] = 1'b0;
          end
          if (s.w_s[1] && wd16[fsp_pkg::FSP_GO_BIT] && s.st == fsp_pkg::FSP_IDLE &&
              n.ctrl[fsp_pkg::FSP_PROGRAM_WRITE_ENABLE_BIT] && s.armed) begin // RQ16 RQ13
            if (n.ctrl[fsp_pkg::FSP_ERASE_BIT]) begin // RQ2
              case (n.ctrl[5:0])
                fsp_pkg::FSP_OP_ERASE1: rsel = fsp_pkg::FSP_ROWS_1;
                fsp_pkg::FSP_OP_ERASE2: rsel = fsp_pkg::FSP_ROWS_2;
                fsp_pkg::FSP_OP_ERASE4: rsel = fsp_pkg::FSP_ROWS_4;
                default:                rsel = 3'h0;
              endcase
              if (rsel == 3'h0) begin
                fail_ev = 1'b1; // RQ17
              end else begin
                blk_mask                    = ~ROW_W'(rsel - 3'h1);
                n.faddr                     = {s.ptr & blk_mask, 5'h00}; // RQ4
                n.rows                      = rsel;
                n.ers                       = 1'b1;
                n.req                       = 1'b1;
                n.st                        = fsp_pkg::FSP_ERASE;
                n.ctrl[fsp_pkg::FSP_GO_BIT] = 1'b1; // RQ14
              end
            end else if (n.ctrl[5:0] == fsp_pkg::FSP_OP_PROG) begin // RQ11
              n.ers                       = 1'b0;
              n.rows                      = fsp_pkg::FSP_ROWS_1;
              n.idx                       = '0;
              n.st                        = fsp_pkg::FSP_FETCH;
              n.ctrl[fsp_pkg::FSP_GO_BIT] = 1'b1; // RQ14
            end else begin
              fail_ev = 1'b1; // RQ17
            end
          end
        end
        fsp_pkg::FSP_PTR_ADDR: begin
          if (s.st == fsp_pkg::FSP_IDLE) begin
            n.ptr = s.w_d[ROW_W-1:0];
          end
        end
        fsp_pkg::FSP_STAT_ADDR: n.stat = s.stat & ~s.w_d[1:0];
        fsp_pkg::FSP_MASK_ADDR: n.mask = s.w_d[1:0];
        default:                n.bresp = fsp_pkg::FSP_SLVERR;
      endcase
    end

    // Events are applied last so a set beats a clear in the same cycle
    if (fail_ev) begin
      n.ctrl[fsp_pkg::FSP_ERR_BIT] = 1'b1; // RQ17
    end
    n.stat[fsp_pkg::FSP_ST_DONE] = n.stat[fsp_pkg::FSP_ST_DONE] | done_ev;
    n.stat[fsp_pkg::FSP_ST_ERR]  = n.stat[fsp_pkg::FSP_ST_ERR] | fail_ev;
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      s      <= '0;
      s.ctrl <= fsp_pkg::FSP_CTRL_RST;
    end else begin
      s <= n;
    end
  end

  assign s_axi_awready = !s.aw_ok && !s.bvalid;
  assign s_axi_wready  = !s.w_ok && !s.bvalid;
  assign s_axi_bvalid  = s.bvalid;
  assign s_axi_bresp   = s.bresp;
  assign s_axi_arready = !s.rvalid;
  assign s_axi_rvalid  = s.rvalid;
  assign s_axi_rdata   = s.rdata;
  assign s_axi_rresp   = s.rresp;
  assign tw_ready      = !s.tw_busy && s.st == fsp_pkg::FSP_IDLE;
  assign flash_req     = s.req;
  assign flash_erase   = s.ers;
  assign flash_addr    = s.faddr;
  assign flash_rows    = s.rows;
  assign flash_wdata   = s.wd;
  assign cpu_stall     = s.st != fsp_pkg::FSP_IDLE; // RQ15
  assign irq           = |(s.stat & s.mask);

  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);

  chk_prog_one_row: assert property ( // RQ3
    flash_req && !flash_erase |-> flash_addr[ROW_W+4:5] == s.ptr && flash_rows == fsp_pkg::FSP_ROWS_1)
    else $error("program left its row");

  chk_erase_align: assert property ( // RQ4
    flash_req && flash_erase |-> flash_addr[4:0] == 5'h00 &&
      (flash_addr[ROW_W+4:5] & ROW_W'(flash_rows - 3'h1)) == '0)
    else $error("erase block misaligned");

  chk_erase_size: assert property ( // RQ2
    flash_req && flash_erase |-> flash_rows inside {3'h1, 3'h2, 3'h4})
    else $error("erase size not one, two or four rows");

  chk_tw_two_cycle: assert property ( // RQ10
    tw_valid && tw_ready |=> !tw_ready ##1 (tw_ready || cpu_stall))
    else $error("table write not two cycles");

  chk_go_unlocked: assert property ( // RQ16
    $rose(cpu_stall) |-> $past(s.armed) && s.ctrl[fsp_pkg::FSP_PROGRAM_WRITE_ENABLE_BIT])
    else $error("operation started without unlock");

  chk_stall_go: assert property ( // RQ15
    cpu_stall == s.ctrl[fsp_pkg::FSP_GO_BIT])
    else $error("stall and go bit disagree");

  chk_go_clears: assert property ( // RQ14
    $fell(cpu_stall) |-> (s.stat[fsp_pkg::FSP_ST_DONE] || s.ctrl[fsp_pkg::FSP_ERR_BIT]))
    else $error("go cleared with no outcome");

  chk_err_sets: assert property ( // RQ17
    flash_req && flash_ack && flash_fail |=> s.ctrl[fsp_pkg::FSP_ERR_BIT] && s.stat[fsp_pkg::FSP_ST_ERR] && !cpu_stall)
    else $error("failure did not set error flag");

  chk_skip_empty: assert property ( // RQ6
    s.st == fsp_pkg::FSP_ISSUE && !lat.rd_loaded |=> !flash_req)
    else $error("unloaded latch was programmed");

  chk_irq_level: assert property ( // RQ17
    flash_req && flash_ack && flash_fail && s.mask[fsp_pkg::FSP_ST_ERR] |=> irq)
    else $error("unmasked failure raised no interrupt");

endmodule : fsp_sequencer
`default_nettype wire

//--- tb/fsp_flash_model.sv
`timescale 1ns/1ps
`default_nettype none
module fsp_flash_model (
  input  wire logic        clock,
  input  wire logic        rst,
  input  wire logic        flash_req,
  input  wire logic        flash_erase,
  input  wire logic [12:0] flash_addr,
  input  wire logic [2:0]  flash_rows,
  input  wire logic [23:0] flash_wdata,
  input  wire logic [3:0]  delay,
  input  wire logic        fail_en,
  output logic             flash_ack,
  output logic             flash_fail
);
  logic [23:0] mem [0:8191];
  logic [3:0]  wait_cnt;
  logic [12:0] last_addr;
  logic [2:0]  last_rows;
  int          n_req = 0;
  initial for (int i = 0; i < 8192; i++) mem[i] = 24'h000000;
  always @(posedge clock or posedge rst) begin
    if (rst) begin
      flash_ack  <= 1'b0;
      flash_fail <= 1'b0;
      wait_cnt   <= 4'h0;
    end else if (flash_req && !flash_ack && wait_cnt >= delay) begin
      flash_ack  <= 1'b1;
      flash_fail <= fail_en;
      wait_cnt   <= 4'h0;
      n_req      <= n_req + 1;
      last_addr  <= flash_addr;
      last_rows  <= flash_rows;
      if (!fail_en && flash_erase) begin
        for (int i = 0; i < 32 * flash_rows; i++) mem[flash_addr + i] = 24'hffffff;
      end else if (!fail_en) begin
        mem[flash_addr] = flash_wdata;
      end
    end else begin
      flash_ack  <= 1'b0;
      // Fail means nothing without ack, so it is kept moving
      flash_fail <= ~flash_fail;
      wait_cnt   <= flash_req ? wait_cnt + 4'h1 : 4'h0;
    end
  end
endmodule : fsp_flash_model
`default_nettype wire

//--- tb/test_fsp_sequencer.sv
`timescale 1ns/1ps
`default_nettype none
module test_fsp_sequencer;
  logic        clock = 1'b0;
  logic        rst = 1'b1;
  logic [15:0] awaddr = 16'h0000;
  logic [15:0] araddr = 16'h0000;
  logic [31:0] wdata = 32'h00000000;
  logic        awvalid = 1'b0;
  logic        wvalid = 1'b0;
  logic        arvalid = 1'b0;
  logic        tw_valid = 1'b0;
  logic [4:0]  tw_index = 5'h00;
  logic [23:0] tw_data = 24'h000000;
  logic [3:0]  delay = 4'h0;
  logic        fail_en = 1'b0;
  logic        awready, wready, bvalid, arready, rvalid, tw_ready;
  logic        flash_req, flash_erase, flash_ack, flash_fail, cpu_stall, irq;
  logic [1:0]  bresp, rresp, rsp;
  logic [31:0] rdata, rd;
  logic [12:0] flash_addr;
  logic [2:0]  flash_rows;
  logic [23:0] flash_wdata;
  int          n_errors = 0;
  int          checks_done = 0;

  fsp_sequencer #(.ROW_W(8)) DUT (
    .clock(clock), .rst(rst),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(1'b1),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(1'b1),
    .tw_valid(tw_valid), .tw_index(tw_index), .tw_data(tw_data), .tw_ready(tw_ready),
    .flash_req(flash_req), .flash_erase(flash_erase), .flash_addr(flash_addr),
    .flash_rows(flash_rows), .flash_wdata(flash_wdata), .flash_ack(flash_ack),
    .flash_fail(flash_fail), .cpu_stall(cpu_stall), .irq(irq)
  );

  fsp_flash_model mdl (
    .clock(clock), .rst(rst), .flash_req(flash_req), .flash_erase(flash_erase),
    .flash_addr(flash_addr), .flash_rows(flash_rows), .flash_wdata(flash_wdata),
    .delay(delay), .fail_en(fail_en), .flash_ack(flash_ack), .flash_fail(flash_fail)
  );

  always #25 clock = ~clock;

  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_errors++;
      $display("MISMATCH %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  task automatic wr(input logic [15:0] a, input logic [31:0] d, output logic [1:0] r);
    logic ah, wh, ad, wd, bh;
    ad = 1'b0;
    wd = 1'b0;
    bh = 1'b0;
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    while (!(ad && wd)) begin
      @(negedge clock);
      ah = awvalid && awready;
      wh = wvalid && wready;
      @(posedge clock);
      if (ah) awvalid <= 1'b0;
      if (wh) wvalid <= 1'b0;
      ad = ad | ah;
      wd = wd | wh;
    end
    // Bready is held high for good, so bvalid alone marks the answer
    while (!bh) begin
      @(negedge clock);
      bh = bvalid;
      r = bresp;
      @(posedge clock);
    end
  endtask : wr

  task automatic rd_reg(input logic [15:0] a, output logic [31:0] d, output logic [1:0] r);
    logic h;
    h = 1'b0;
    araddr <= a;
    arvalid <= 1'b1;
    while (!h) begin
      @(negedge clock);
      h = arready;
      @(posedge clock);
    end
    arvalid <= 1'b0;
    h = 1'b0;
    while (!h) begin
      @(negedge clock);
      h = rvalid;
      d = rdata;
      r = rresp;
      @(posedge clock);
    end
  endtask : rd_reg

  task automatic expect_reg(input string name, input logic [15:0] a, input logic [31:0] exp, input logic [31:0] m);
    rd_reg(a, rd, rsp);
    check(name, rd & m, exp);
  endtask : expect_reg

  task automatic tw(input logic [4:0] i, input logic [23:0] d);
    logic h;
    h = 1'b0;
    tw_index <= i;
    tw_data <= d;
    tw_valid <= 1'b1;
    while (!h) begin
      @(negedge clock);
      h = tw_ready;
      @(posedge clock);
    end
    tw_valid <= 1'b0;
    @(negedge clock);
    check("tw_second_cycle", tw_ready, 1'b0);
    @(posedge clock);
  endtask : tw

  function automatic logic [31:0] ctl(input logic e, input logic [5:0] op);
    return {16'h0000, 2'h3, 7'h00, e, op};
  endfunction : ctl

  task automatic launch(input logic [31:0] v);
    wr(fsp_pkg::FSP_KEY_ADDR, {24'h000000, fsp_pkg::FSP_KEY1}, rsp);
    wr(fsp_pkg::FSP_KEY_ADDR, {24'h000000, fsp_pkg::FSP_KEY2}, rsp);
    wr(fsp_pkg::FSP_CTRL_ADDR, v, rsp);
  endtask : launch

  task automatic run_op(input logic [31:0] v);
    int n;
    n = 0;
    launch(v);
    @(negedge clock);
    check("stall_during_op", cpu_stall, 1'b1);
    check("tw_refused_busy", tw_ready, 1'b0);
    while (cpu_stall !== 1'b0 && n < 400) begin
      @(negedge clock);
      n++;
    end
    check("stall_released", cpu_stall, 1'b0);
    @(posedge clock);
    expect_reg("go_cleared", fsp_pkg::FSP_CTRL_ADDR, 32'h0, 32'h8000);
  endtask : run_op

  task automatic t_reset();
    expect_reg("ctrl_reset", fsp_pkg::FSP_CTRL_ADDR, 32'h0, 32'hffffffff);
    expect_reg("key_reads_zero", fsp_pkg::FSP_KEY_ADDR, 32'h0, 32'hffffffff);
    rd_reg(16'h0100, rd, rsp);
    check("unmapped_rresp", rsp, fsp_pkg::FSP_SLVERR);
    check("unmapped_rdata", rd, 32'h0);
    wr(16'h0100, 32'h1, rsp);
    check("unmapped_bresp", rsp, fsp_pkg::FSP_SLVERR);
    check("irq_reset", irq, 1'b0);
  endtask : t_reset

  task automatic t_erase();
    logic [5:0] ops [3];
    int         rows [3];
    int         base;
    ops = '{fsp_pkg::FSP_OP_ERASE1, fsp_pkg::FSP_OP_ERASE2, fsp_pkg::FSP_OP_ERASE4};
    rows = '{1, 2, 4};
    delay <= 4'h5;
    for (int i = 0; i < 3; i++) begin
      // Row 7 is odd, so the two- and four-row block sizes have to round it down
      wr(fsp_pkg::FSP_PTR_ADDR, 32'h7, rsp);
      run_op(ctl(1'b1, ops[i]));
      base = (7 / rows[i]) * rows[i] * 32;
      check("erase_addr", mdl.last_addr, base);
      check("erase_rows", mdl.last_rows, rows[i]);
      check("erase_before_block", mdl.mem[base - 1], 24'h000000);
    end
    expect_reg("status_done", fsp_pkg::FSP_STAT_ADDR, 32'h1, 32'h1);
    check("irq_masked", irq, 1'b0);
  endtask : t_erase

  task automatic t_program();
    int n0;
    delay <= 4'h0;
    n0 = mdl.n_req;
    wr(fsp_pkg::FSP_PTR_ADDR, 32'h5, rsp);
    tw(5'h03, 24'h111111);
    tw(5'h00, 24'h222222);
    tw(5'h1f, 24'h333333);
    tw(5'h03, 24'h444444);
    check("no_array_access", mdl.n_req, n0);
    run_op(ctl(1'b0, fsp_pkg::FSP_OP_PROG));
    check("prog_requests", mdl.n_req, n0 + 3);
    check("prog_word0", mdl.mem[160], 24'h222222);
    check("prog_reload", mdl.mem[163], 24'h444444);
    check("prog_word31", mdl.mem[191], 24'h333333);
    check("prog_unloaded", mdl.mem[161], 24'hffffff);
    check("prog_next_row", mdl.mem[192], 24'hffffff);
    n0 = mdl.n_req;
    // Launch a second program with no fresh loads; the cleared latches mean no array writes
    run_op(ctl(1'b0, fsp_pkg::FSP_OP_PROG));
    check("reprogram_needs_loads", mdl.n_req, n0);
  endtask : t_program

  task automatic t_lockout();
    int n0;
    n0 = mdl.n_req;
    wr(fsp_pkg::FSP_CTRL_ADDR, ctl(1'b1, fsp_pkg::FSP_OP_ERASE1), rsp);
    wr(fsp_pkg::FSP_KEY_ADDR, {24'h000000, fsp_pkg::FSP_KEY1}, rsp);
    wr(fsp_pkg::FSP_PTR_ADDR, 32'h4, rsp);
    wr(fsp_pkg::FSP_KEY_ADDR, {24'h000000, fsp_pkg::FSP_KEY2}, rsp);
    wr(fsp_pkg::FSP_CTRL_ADDR, ctl(1'b1, fsp_pkg::FSP_OP_ERASE1), rsp);
    launch(32'h00008058);
    repeat (5) @(posedge clock);
    check("locked_no_request", mdl.n_req, n0);
    check("locked_no_stall", cpu_stall, 1'b0);
  endtask : t_lockout

  task automatic t_fail();
    fail_en <= 1'b1;
    wr(fsp_pkg::FSP_PTR_ADDR, 32'h6, rsp);
    wr(fsp_pkg::FSP_MASK_ADDR, 32'h2, rsp);
    tw(5'h02, 24'h123456);
    run_op(ctl(1'b0, fsp_pkg::FSP_OP_PROG));
    fail_en <= 1'b0;
    expect_reg("error_flag", fsp_pkg::FSP_CTRL_ADDR, 32'h2000, 32'h2000);
    expect_reg("status_error", fsp_pkg::FSP_STAT_ADDR, 32'h2, 32'h2);
    @(negedge clock);
    check("irq_raised", irq, 1'b1);
    @(posedge clock);
    wr(fsp_pkg::FSP_STAT_ADDR, 32'h3, rsp);
    @(negedge clock);
    check("irq_cleared", irq, 1'b0);
    @(posedge clock);
    expect_reg("error_sticky", fsp_pkg::FSP_CTRL_ADDR, 32'h2000, 32'h2000);
    wr(fsp_pkg::FSP_CTRL_ADDR, 32'h0, rsp);
    expect_reg("error_cleared", fsp_pkg::FSP_CTRL_ADDR, 32'h0, 32'h2000);
    launch(ctl(1'b1, 6'h3f));
    expect_reg("bad_op_error", fsp_pkg::FSP_CTRL_ADDR, 32'h2000, 32'ha000);
  endtask : t_fail

  task automatic final_report();
    $display("checks_done=%0d n_errors=%0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : final_report

  initial begin
    repeat (20) @(posedge clock);
    rst <= 1'b0;
    @(posedge clock);
    t_reset();
    t_erase();
    t_program();
    t_lockout();
    t_fail();
    final_report();
  end

  // Whole sequence needs well under 2000 cycles
  initial begin
    #(50 * 20000);
    n_errors++;
    $display("MISMATCH watchdog expected done seen hang");
    final_report();
  end
endmodule : test_fsp_sequencer
`default_nettype wire
